// [reset_test_strap_sampling.sv]
// reset release sequencing and test strap capture
// assumes resetn_i is the chip reset pin, already debounced by its buffer,
// and that strap pins have weak pulldowns outside this logic
//
// Summary of operation
// RULE1 - reset pin active low, rising edge starts configuration
// RULE2 - reset driver releases only after supplies stable
// RULE3 - no output active while reset held low
// RULE4 - strap pins high impedance during reset
// RULE5 - sample strap pins about 1.5 us after release
// RULE6 - after sampling, drive strap pins as outputs
// RULE7 - high strap selects test mode; keep low
// RULE8 - scan reset input strapped low externally
// RULE9 - strap selection held until next reset
`include "strap_params.svh"
`default_nettype none
module reset_test_strap_sampling #(
  parameter int SAMPLE_CYCLES = `STRAP_SAMPLE_CYCLES,
  parameter int PIN_COUNT     = `STRAP_PIN_COUNT
) (
  // clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 resetn_i,
  // factory scan reset strap
  input  wire logic                 factory_scan_reset_n_i,
  // test strap pins
  input  wire logic [PIN_COUNT-1:0] test_strap_pin_i,
  output var  logic [PIN_COUNT-1:0] test_strap_pin_o,
  output var  logic [PIN_COUNT-1:0] test_strap_pin_oe_o,
  // test output data from the core
  input  wire logic [PIN_COUNT-1:0] test_out_data_i,
  // configuration status
  output var  logic                 config_start_o,
  output var  logic                 config_active_o,
  output var  logic [PIN_COUNT-1:0] test_mode_sel_o,
  output var  logic                 test_mode_o,
  output var  logic                 scan_strap_fault_o
);
  localparam int CW = $clog2(SAMPLE_CYCLES + 1);

  initial begin
    if (SAMPLE_CYCLES < 1 || PIN_COUNT != `STRAP_PIN_COUNT)
      $error("reset_test_strap_sampling: unsupported parameters");
  end

  logic [PIN_COUNT-1:0]    strap_sync;
  logic                    scan_sync;
  strap_pkg::seq_state_t   state_r;
  strap_pkg::seq_state_t   state_nxt;
  logic [CW-1:0]           cnt_r;
  logic [CW-1:0]           cnt_nxt;
  logic [PIN_COUNT-1:0]    sel_nxt;
  logic [PIN_COUNT-1:0]    pin_nxt;
  logic [PIN_COUNT-1:0]    oe_nxt;
  logic                    start_nxt;
  logic                    active_nxt;
  logic                    mode_nxt;
  logic                    fault_nxt;
  logic                    leave_held;
  logic                    sample_now;

  // pins are asynchronous to the core clock
  reset_sync #(
    .WIDTH (PIN_COUNT + 1)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .async_i    ({factory_scan_reset_n_i, test_strap_pin_i}),
    .sync_o     ({scan_sync, strap_sync})
  );

  // any high strap leaves normal operation
  function automatic logic is_test_code(
    input logic [PIN_COUNT-1:0] code
  );
    return (code != `STRAP_MODE_NORMAL);
  endfunction

  // sequencer: held, counting the sample delay, then driving
  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    leave_held = 1'b0;
    sample_now = 1'b0;
    case (state_r)
      strap_pkg::ST_HELD: begin
        // first clocked cycle after release is the rising edge
        state_nxt  = strap_pkg::ST_WAIT; // RULE1
        leave_held = 1'b1; // RULE1
        cnt_nxt    = '0;
      end
      strap_pkg::ST_WAIT: begin
        if (cnt_r == CW'(SAMPLE_CYCLES - 1)) begin
          // sync delay is inside the window, so sample stays near 1.5 us
          sample_now = 1'b1; // RULE5
          state_nxt  = strap_pkg::ST_DRIVE;
        end else begin
          cnt_nxt = cnt_r + CW'(1);
        end
      end
      strap_pkg::ST_DRIVE: begin
        // only a reset leaves this state
        state_nxt = strap_pkg::ST_DRIVE; // RULE9
      end
      default: begin
        state_nxt = strap_pkg::ST_HELD;
      end
    endcase
  end

  // async clear restarts the sequence on every reset
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= strap_pkg::ST_HELD;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // status: one start pulse, then active until reset
  always_comb begin
    start_nxt  = leave_held; // RULE1
    active_nxt = config_active_o | leave_held;
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      config_start_o  <= 1'b0; // RULE3
      config_active_o <= 1'b0; // RULE3
    end else begin
      config_start_o  <= start_nxt;
      config_active_o <= active_nxt;
    end
  end

  // capture: loaded once per release, held after
  always_comb begin
    sel_nxt   = test_mode_sel_o; // RULE9
    mode_nxt  = test_mode_o;
    fault_nxt = scan_strap_fault_o;
    if (sample_now) begin
      sel_nxt   = strap_sync; // RULE5
      mode_nxt  = is_test_code(strap_sync); // RULE7
      // scan strap high risks a failed start-up
      fault_nxt = scan_sync; // RULE8
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      test_mode_sel_o    <= `STRAP_MODE_NORMAL; // RULE9
      test_mode_o        <= 1'b0; // RULE3
      scan_strap_fault_o <= 1'b0; // RULE3
    end else begin
      test_mode_sel_o    <= sel_nxt;
      test_mode_o        <= mode_nxt;
      scan_strap_fault_o <= fault_nxt;
    end
  end

  // drive: pins float until the sample is taken
  always_comb begin
    pin_nxt = '0;
    oe_nxt  = '0; // RULE4
    if (state_r == strap_pkg::ST_DRIVE) begin
      // one cycle of lag on the data, traded for a clean pin
      pin_nxt = test_out_data_i; // RULE6
      oe_nxt  = '1; // RULE6
    end
  end

  // async clear floats the pins at once, no clock needed
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      test_strap_pin_o    <= '0; // RULE3
      test_strap_pin_oe_o <= '0; // RULE4
    end else begin
      test_strap_pin_o    <= pin_nxt;
      test_strap_pin_oe_o <= oe_nxt;
    end
  end
endmodule
`default_nettype wire

// [strap_params.svh]
// constants for the reset release and test strap capture block
// assumes a 250 MHz core clock
`ifndef STRAP_PARAMS_SVH
`define STRAP_PARAMS_SVH
`define STRAP_CLK_MHZ        250
`define STRAP_SAMPLE_NS      1500
`define STRAP_SAMPLE_CYCLES  ((`STRAP_SAMPLE_NS * `STRAP_CLK_MHZ) / 1000)
`define STRAP_PIN_COUNT      8
`define STRAP_MODE_NORMAL    8'h00
`endif

// [strap_pkg.sv]
// types for the reset release and test strap capture block
// assumes strap_params.svh is compiled alongside
`default_nettype none
package strap_pkg;
  typedef enum logic [1:0] {
    ST_HELD   = 2'b00,
    ST_WAIT   = 2'b01,
    ST_DRIVE  = 2'b11
  } seq_state_t;
endpackage
`default_nettype wire

// [reset_sync.sv]
// two-flop synchroniser for an asynchronous pin level
// assumes one core clock and an active-low asynchronous reset
`default_nettype none
module reset_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             resetn_i,
  // level in and out
  input  wire logic [WIDTH-1:0] async_i,
  output var  logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_nxt;

  always_comb begin
    meta_nxt = async_i;
    sync_nxt = meta_r;
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_o <= sync_nxt;
    end
  end
endmodule
`default_nettype wire

// [rts_chk.sv]
// port checks for the strap block
// assumes SAMPLE_CYCLES of 4
`default_nettype none
module rts_chk (
  // watched ports
  input wire logic       core_clk_i,
  input wire logic       resetn_i,
  input wire logic [7:0] test_strap_pin_o,
  input wire logic [7:0] test_strap_pin_oe_o,
  input wire logic [7:0] test_out_data_i,
  input wire logic       config_start_o,
  input wire logic [7:0] test_mode_sel_o,
  input wire logic       test_mode_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_rel; $rose(resetn_i); endsequence
  sequence s_float; (test_strap_pin_oe_o == 8'h00) [*5]; endsequence
  chk_start_pulse: assert property (
    s_rel |-> ##1 config_start_o ##1 !config_start_o) else $error("start");
  chk_pin_release: assert property (
    s_rel |-> ##1 s_float ##1 test_strap_pin_oe_o == 8'hff) else $error("oe");
  chk_no_early: assert property (
    s_rel |-> ##1 (test_mode_sel_o == 8'h00) [*4]) else $error("early");
  chk_sel_hold: assert property (
    test_strap_pin_oe_o[0] |=> $stable(test_mode_sel_o)) else $error("hold");
  chk_mode_any: assert property (
    test_mode_o == (|test_mode_sel_o)) else $error("mode");
  chk_drive_lag: assert property (
    test_strap_pin_oe_o[0] |-> test_strap_pin_o == $past(test_out_data_i))
    else $error("drive");
  chk_reset_quiet: assert property (disable iff (1'b0)
    !resetn_i |-> !(config_start_o | test_mode_o | test_strap_pin_oe_o[0]))
    else $error("quiet");
endmodule
bind reset_test_strap_sampling rts_chk rts_chk_inst (.*);
`default_nettype wire

// [strap_board.sv]
// board model: reset driver and strap pulls
// assumes weak pulldowns on every strap pin
`default_nettype none
module strap_board (
  // bench control
  input  wire logic       core_clk_i,
  input  wire logic       power_ok_i,
  input  wire logic [7:0] pull_up_i,
  // pins
  input  wire logic [7:0] pin_drv_i,
  input  wire logic [7:0] pin_oe_i,
  output var  logic       resetn_o,
  output logic            scan_n_o,
  output logic [7:0]      pin_lvl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // release one edge after supplies settle
  always_ff @(posedge core_clk_i or negedge power_ok_i)
    if (!power_ok_i) resetn_o <= 1'b0;
    else resetn_o <= 1'b1;
  assign scan_n_o = 1'b0;
  // floating pins fall low unless pulled up
  assign pin_lvl_o = (pin_oe_i & pin_drv_i) | (~pin_oe_i & pull_up_i);
endmodule
`default_nettype wire

// [reset_test_strap_sampling_bench.sv]
// bench for the strap block
// assumes board model and checker compiled first
`default_nettype none
module reset_test_strap_sampling_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       pwr = 1'b0;
  logic [7:0] pull = 8'h00;
  logic [7:0] dat = 8'h3c;
  logic       rstn, scn, start, act, mode, flt;
  logic [7:0] lvl, pin_o, oe, sel;
  int         err_total = 0;
  int         compares = 0;
  always #2 clk = ~clk;
  strap_board strap_board_inst (.core_clk_i(clk), .power_ok_i(pwr),
    .pull_up_i(pull), .pin_drv_i(pin_o), .pin_oe_i(oe), .resetn_o(rstn),
    .scan_n_o(scn), .pin_lvl_o(lvl));
  reset_test_strap_sampling #(.SAMPLE_CYCLES(4))
    reset_test_strap_sampling_inst (.core_clk_i(clk), .resetn_i(rstn),
    .factory_scan_reset_n_i(scn), .test_strap_pin_i(lvl),
    .test_strap_pin_o(pin_o), .test_strap_pin_oe_o(oe),
    .test_out_data_i(dat), .config_start_o(start), .config_active_o(act),
    .test_mode_sel_o(sel), .test_mode_o(mode), .scan_strap_fault_o(flt));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic summarize();
    $display("errors=%0d compares=%0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one power cycle; straps moved after capture must not count
  task automatic boot(input logic [7:0] p);
    int n;
    @(posedge clk) pwr <= 1'b0;
    pull <= p;
    repeat (6) @(negedge clk);
    chk(oe, 8'h00);
    chk(act, 1'b0);
    @(posedge clk) pwr <= 1'b1;
    for (n = 0; n < 9 && start !== 1'b1; n++) @(negedge clk);
    if (n == 9) begin
      err_total++;
      summarize();
    end
    chk(act, 1'b1);
    repeat (4) @(negedge clk);
    chk(sel, p);
    chk(mode, |p);
    chk(flt, 8'h00);
    chk(oe, 8'h00);
    @(negedge clk);
    chk(oe, 8'hff);
    @(posedge clk) pull <= ~p;
    dat <= ~dat;
    repeat (2) @(negedge clk);
    chk(pin_o, dat);
    chk(sel, p);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    boot(8'h00);
    boot(8'h5a);
    boot(8'h81);
    summarize();
  end
endmodule
`default_nettype wire
